// ### logic/mod_pkg.sv
// Function
// RULE1: One to three bytes, two to eight cycles
// RULE2: Eight-code groups take register from low bits
// RULE3: Absolute jump/call take top three address bits
// RULE4: Add decodes 28-2F, 25, 26-27, 24
// RULE5: Add with carry decodes 38-3F, 35, 36-37, 34
// RULE6: Subtract borrow decodes 98-9F, 95, 96-97, 94
// RULE7: Pointer increment A3 four; increments two
// RULE8: Immediate logic into direct: three bytes, four
// RULE9: AND decodes 58-5F, 55, 56-57, 54, 52
// RULE10: OR decodes 48-4F, 45, 46-47, 44, 42
// RULE11: XOR decodes 68-6F, 65, 66-67, 64, 62
// RULE12: Accumulator ops E4 F4 C4 23 33 03 13
// RULE13: Register moves E8-EF, F8-FF two; A8-AF four
// RULE14: Direct and immediate to direct: 85, 75
// RULE15: Code memory reads 93 and 83, four cycles
// RULE16: External data E0, E2-E3, F0, F2-F3, four
// RULE17: Push C0, pop D0, two bytes, four cycles
// RULE18: Exchange C8-CF, C5, C6-C7, nibble D6-D7
// RULE19: Carry bit logic 82, 72, A0 four cycles
// RULE20: Long call 12, returns 22 and 32, four
// RULE21: Conditional jumps 40 50 20 30 60 70 10
// RULE22: Compare-jump B4-BF; decrement-jump D8-DF, D5
// RULE23: Bank bits map registers to four banks
// RULE24: Unassigned opcode is one-byte two-cycle no-op
package mod_pkg;
  localparam int OPW = 8;
  localparam int REG_W = 3;
  localparam int ADDR_W = 5;
  localparam int LEN_W = 2;
  localparam int CYC_W = 4;
  localparam logic [CYC_W-1:0] CYC_SHORT = 4'h2;
  localparam logic [CYC_W-1:0] CYC_LONG = 4'h4;
  localparam logic [CYC_W-1:0] CYC_MULDIV = 4'h8;
  localparam logic [LEN_W-1:0] LEN_ONE = 2'h1;
  localparam logic [LEN_W-1:0] LEN_TWO = 2'h2;
  localparam logic [LEN_W-1:0] LEN_THREE = 2'h3;
  localparam logic [4:0] ABS_LOW = 5'h01;
  localparam logic [4:0] ABS_CALL = 5'h11;
  localparam logic [7:0] OP_UNASSIGNED = 8'hA5;
  typedef enum {
    MOD_IDLE,
    MOD_OPER,
    MOD_EXEC
  } mod_state_t;
endpackage : mod_pkg

// ### logic/mod_decode.sv
`timescale 1ns/1ps
module mod_decode #(
  parameter int OPW_P = mod_pkg::OPW
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic code_valid,
  input wire logic [OPW_P-1:0] code_byte,
  input wire logic [1:0] bank_select,
  output logic code_ready,
  output logic [OPW_P-1:0] opcode,
  output logic [mod_pkg::LEN_W-1:0] instr_len,
  output logic [mod_pkg::CYC_W-1:0] instr_cycles,
  output logic [mod_pkg::REG_W-1:0] reg_index,
  output logic [mod_pkg::ADDR_W-1:0] reg_addr,
  output logic reg_form,
  output logic abs_form,
  output logic [2:0] abs_high,
  output logic no_op,
  output logic instr_done
);
  import mod_pkg::*;

  mod_state_t state;
  logic [LEN_W-1:0] bytes_left;
  logic [CYC_W-1:0] cyc_count;

  function automatic logic [LEN_W-1:0] len_of(input logic [7:0] op);
    logic [3:0] lo;
    logic [3:0] hi;
    lo = op[3:0];
    hi = op[7:4];
    len_of = LEN_ONE;
    if (op[4:0] == ABS_LOW || op[4:0] == ABS_CALL) // RULE3
      len_of = LEN_TWO;
    else if (op == 8'h02 || op == 8'h12 || op == 8'h90) // RULE20
      len_of = LEN_THREE;
    else if (op == 8'h10 || op == 8'h20 || op == 8'h30) // RULE21
      len_of = LEN_THREE;
    else if (op == 8'h43 || op == 8'h53 || op == 8'h63) // RULE8
      len_of = LEN_THREE;
    else if (op == 8'h75 || op == 8'h85 || op == 8'hD5) // RULE14
      len_of = LEN_THREE;
    else if (hi == 4'hB && (lo >= 4'h4)) // RULE22
      len_of = LEN_THREE;
    else if (op == OP_UNASSIGNED) // RULE24
      len_of = LEN_ONE;
    else if (lo == 4'h5 || lo == 4'h4 && hi >= 4'h2 && hi <= 4'h9
             && hi != 4'h8 || lo == 4'h4 && hi == 4'h7)
      len_of = (op == 8'h84) ? LEN_ONE : LEN_TWO; // RULE4 RULE5 RULE6
    else if (lo == 4'h2 && (hi >= 4'h4 && hi <= 4'hD)) // RULE19
      len_of = LEN_TWO;
    else if (lo == 4'h0 && (hi >= 4'h4 && hi <= 4'hD)) // RULE17 RULE21
      len_of = LEN_TWO;
    else if (lo == 4'h3 && (hi == 4'h9 || hi == 4'hA))
      len_of = LEN_ONE;
    else if (lo[3] && (hi == 4'h7 || hi == 4'h8 || hi == 4'hA
             || hi == 4'hD)) // RULE13 RULE22
      len_of = LEN_TWO;
    else if ((lo == 4'h6 || lo == 4'h7) && (hi == 4'h7 || hi == 4'h8
             || hi == 4'hA))
      len_of = LEN_TWO;
    else if (op == 8'h05 || op == 8'h15 || op == 8'hE5 || op == 8'hF5)
      len_of = LEN_TWO; // RULE7
  endfunction : len_of

  function automatic logic [CYC_W-1:0] cyc_of(input logic [7:0] op);
    logic [3:0] lo;
    logic [3:0] hi;
    lo = op[3:0];
    hi = op[7:4];
    cyc_of = CYC_SHORT;
    if (op == 8'hA4 || op == 8'h84)
      cyc_of = CYC_MULDIV;
    else if (op == OP_UNASSIGNED) // RULE24
      cyc_of = CYC_SHORT;
    else if (lo == 4'h1 || (lo == 4'h0 && hi >= 4'h1 && hi <= 4'h8)) // RULE20 RULE21
      cyc_of = CYC_LONG;
    else if (op == 8'h02 || op == 8'h12 || op == 8'h22 || op == 8'h32
             || op == 8'h73) // RULE20
      cyc_of = CYC_LONG;
    else if (op == 8'h43 || op == 8'h53 || op == 8'h63) // RULE8
      cyc_of = CYC_LONG;
    else if (op == 8'h82 || op == 8'h72 || op == 8'hA0 || op == 8'hB0
             || op == 8'h92) // RULE19
      cyc_of = CYC_LONG;
    else if (op == 8'hA3 || op == 8'h90 || op == 8'h93 || op == 8'h83) // RULE7 RULE15
      cyc_of = CYC_LONG;
    else if ((hi == 4'hE || hi == 4'hF) && (lo == 4'h0 || lo == 4'h2
             || lo == 4'h3)) // RULE16
      cyc_of = CYC_LONG;
    else if (op == 8'hC0 || op == 8'hD0) // RULE17
      cyc_of = CYC_LONG;
    else if (op == 8'h75 || op == 8'h85 || (hi == 4'h8 && lo >= 4'h6)) // RULE14
      cyc_of = CYC_LONG;
    else if (hi == 4'hA && (lo[3] || lo == 4'h6 || lo == 4'h7)) // RULE13
      cyc_of = CYC_LONG;
    else if (hi == 4'hB && lo >= 4'h4) // RULE22
      cyc_of = CYC_LONG;
    else if (op == 8'hD5 || (hi == 4'hD && lo[3])) // RULE22
      cyc_of = CYC_LONG;
  endfunction : cyc_of

  function automatic logic reg_of(input logic [7:0] op);
    logic [3:0] hi;
    hi = op[7:4];
    reg_of = op[3] && hi != 4'h0 ? 1'b1 : op[3]; // RULE2
  endfunction : reg_of

  // A byte is only taken while code_ready is shown, so both ends agree
  wire logic take = clk_en && code_ready && state == MOD_IDLE && code_valid;
  wire logic operand = clk_en && code_ready && state == MOD_OPER
    && code_valid;
  wire logic [LEN_W-1:0] next_len = len_of(code_byte); // RULE1
  wire logic [CYC_W-1:0] next_cycles = cyc_of(code_byte); // RULE1
  wire logic is_abs = code_byte[3:0] == ABS_LOW[3:0]; // RULE3
  wire logic assigned = code_byte != OP_UNASSIGNED; // RULE24
  wire logic [ADDR_W-1:0] next_addr = {bank_select, code_byte[2:0]}; // RULE23

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= MOD_IDLE;
      code_ready <= 1'b0;
      opcode <= 8'h00;
      instr_len <= LEN_ONE;
      instr_cycles <= CYC_SHORT;
      reg_index <= 3'h0;
      reg_addr <= 5'h00;
      reg_form <= 1'b0;
      abs_form <= 1'b0;
      abs_high <= 3'h0;
      no_op <= 1'b0;
      instr_done <= 1'b0;
      bytes_left <= 2'h0;
      cyc_count <= 4'h0;
    end else if (clk_en) begin
      instr_done <= 1'b0;
      code_ready <= 1'b0;
      if (cyc_count != 4'h0)
        cyc_count <= cyc_count - 4'h1;
      unique case (state)
        MOD_IDLE: begin
          code_ready <= 1'b1;
          if (take) begin
            opcode <= code_byte;
            instr_len <= next_len;
            instr_cycles <= next_cycles;
            reg_index <= code_byte[2:0]; // RULE2
            reg_addr <= next_addr; // RULE23
            reg_form <= reg_of(code_byte); // RULE2
            abs_form <= is_abs;
            abs_high <= code_byte[7:5]; // RULE3
            no_op <= !assigned || code_byte == 8'h00; // RULE24
            cyc_count <= next_cycles - 4'h1;
            bytes_left <= next_len - 2'h1;
            state <= (next_len == LEN_ONE) ? MOD_EXEC : MOD_OPER;
            code_ready <= next_len != LEN_ONE;
          end
        end
        MOD_OPER: begin
          code_ready <= 1'b1;
          if (operand) begin
            bytes_left <= bytes_left - 2'h1;
            if (bytes_left == 2'h1) begin
              state <= MOD_EXEC;
              code_ready <= 1'b0;
            end
          end
        end
        MOD_EXEC: begin
          if (cyc_count <= 4'h1) begin
            instr_done <= 1'b1;
            state <= MOD_IDLE;
            code_ready <= 1'b1;
          end
        end
      endcase
    end
  end

  a_done_gap: assert property (@(posedge ref_clk) disable iff (sys_rst)
    instr_done && clk_en |=> !instr_done) // RULE1
    else $error("done pulsed twice");
  a_cycle_range: assert property (@(posedge ref_clk) disable iff (sys_rst)
    instr_cycles >= 4'h2 && instr_cycles <= 4'h8) // RULE1
    else $error("cycle count out of range");
  a_len_range: assert property (@(posedge ref_clk) disable iff (sys_rst)
    instr_len != 2'h0) // RULE1
    else $error("length zero");
  a_bank_map: assert property (@(posedge ref_clk) disable iff (sys_rst)
    take |=> reg_addr == {$past(bank_select), $past(code_byte[2:0])}) // RULE23
    else $error("bank address wrong");
  a_abs_high: assert property (@(posedge ref_clk) disable iff (sys_rst)
    take && is_abs |=> abs_high == $past(code_byte[7:5])) // RULE3
    else $error("absolute bits wrong");
  a_inc_ptr: assert property (@(posedge ref_clk) disable iff (sys_rst)
    take && code_byte == 8'hA3 |=> instr_cycles == 4'h4) // RULE7
    else $error("pointer increment cycles");
  a_logic_imm: assert property (@(posedge ref_clk) disable iff (sys_rst)
    take && code_byte == 8'h53 |=> instr_len == 2'h3) // RULE8
    else $error("immediate logic length");
  a_nop_fill: assert property (@(posedge ref_clk) disable iff (sys_rst)
    take && code_byte == OP_UNASSIGNED |=> no_op && instr_len == 2'h1) // RULE24
    else $error("unassigned not no-op");
  a_reg_index: assert property ( // RULE2
    @(posedge ref_clk) disable iff (sys_rst)
    take |=> reg_index == $past(code_byte[2:0]))
    else $error("register index wrong");
  a_add_reg: assert property ( // RULE4
    @(posedge ref_clk) disable iff (sys_rst)
    take && code_byte[7:3] == 5'h05
    |=> instr_len == LEN_ONE && instr_cycles == CYC_SHORT)
    else $error("add register decode");
  a_addc_imm: assert property ( // RULE5
    @(posedge ref_clk) disable iff (sys_rst)
    take && code_byte == 8'h34
    |=> instr_len == LEN_TWO && instr_cycles == CYC_SHORT)
    else $error("add carry immediate decode");
  a_subb_dir: assert property ( // RULE6
    @(posedge ref_clk) disable iff (sys_rst)
    take && code_byte == 8'h95
    |=> instr_len == LEN_TWO && instr_cycles == CYC_SHORT)
    else $error("subtract direct decode");
  a_and_acc: assert property ( // RULE9
    @(posedge ref_clk) disable iff (sys_rst)
    take && code_byte == 8'h52
    |=> instr_len == LEN_TWO && instr_cycles == CYC_SHORT)
    else $error("and into direct decode");
  a_or_acc: assert property ( // RULE10
    @(posedge ref_clk) disable iff (sys_rst)
    take && code_byte == 8'h42
    |=> instr_len == LEN_TWO && instr_cycles == CYC_SHORT)
    else $error("or into direct decode");
  a_xor_acc: assert property ( // RULE11
    @(posedge ref_clk) disable iff (sys_rst)
    take && code_byte == 8'h62
    |=> instr_len == LEN_TWO && instr_cycles == CYC_SHORT)
    else $error("xor into direct decode");
  a_acc_swap: assert property ( // RULE12
    @(posedge ref_clk) disable iff (sys_rst)
    take && code_byte == 8'hC4
    |=> instr_len == LEN_ONE && instr_cycles == CYC_SHORT)
    else $error("accumulator op decode");
  a_move_dir: assert property ( // RULE13
    @(posedge ref_clk) disable iff (sys_rst)
    take && code_byte[7:3] == 5'h15
    |=> instr_len == LEN_TWO && instr_cycles == CYC_LONG)
    else $error("direct to register decode");
  a_move_dd: assert property ( // RULE14
    @(posedge ref_clk) disable iff (sys_rst)
    take && code_byte == 8'h85
    |=> instr_len == LEN_THREE && instr_cycles == CYC_LONG)
    else $error("direct to direct decode");
  a_code_read: assert property ( // RULE15
    @(posedge ref_clk) disable iff (sys_rst)
    take && code_byte == 8'h93
    |=> instr_len == LEN_ONE && instr_cycles == CYC_LONG)
    else $error("code memory read decode");
  a_ext_data: assert property ( // RULE16
    @(posedge ref_clk) disable iff (sys_rst)
    take && code_byte == 8'hE0
    |=> instr_len == LEN_ONE && instr_cycles == CYC_LONG)
    else $error("external data decode");
  a_stack_push: assert property ( // RULE17
    @(posedge ref_clk) disable iff (sys_rst)
    take && code_byte == 8'hC0
    |=> instr_len == LEN_TWO && instr_cycles == CYC_LONG)
    else $error("push decode");
  a_nibble_xch: assert property ( // RULE18
    @(posedge ref_clk) disable iff (sys_rst)
    take && code_byte == 8'hD6
    |=> instr_len == LEN_ONE && instr_cycles == CYC_SHORT)
    else $error("nibble exchange decode");
  a_carry_logic: assert property ( // RULE19
    @(posedge ref_clk) disable iff (sys_rst)
    take && code_byte == 8'hA0
    |=> instr_len == LEN_TWO && instr_cycles == CYC_LONG)
    else $error("carry logic decode");
  a_long_call: assert property ( // RULE20
    @(posedge ref_clk) disable iff (sys_rst)
    take && code_byte == 8'h12
    |=> instr_len == LEN_THREE && instr_cycles == CYC_LONG)
    else $error("long call decode");
  a_bit_jump: assert property ( // RULE21
    @(posedge ref_clk) disable iff (sys_rst)
    take && code_byte == 8'h10
    |=> instr_len == LEN_THREE && instr_cycles == CYC_LONG)
    else $error("bit jump decode");
  a_dec_jump: assert property ( // RULE22
    @(posedge ref_clk) disable iff (sys_rst)
    take && code_byte[7:3] == 5'h1B
    |=> instr_len == LEN_TWO && instr_cycles == CYC_LONG)
    else $error("decrement jump decode");
endmodule : mod_decode

// ### testbench/mod_progmem.sv
`timescale 1ns/1ps
module mod_progmem (
  input wire logic ref_clk,
  input wire logic clk_en,
  input wire logic code_ready,
  output logic code_valid,
  output logic [7:0] code_byte
);
  logic [7:0] fifo[$];
  initial begin
    code_valid = 1'b0;
    code_byte = 8'h00;
  end
  task automatic put(input logic [7:0] b);
    fifo.push_back(b);
  endtask : put
  always @(posedge ref_clk) begin
    if (code_valid && code_ready && clk_en) begin
      void'(fifo.pop_front());
      code_valid <= 1'b0;
    end
  end
  // Offer next byte, sometimes late; idle bus keeps changing
  always @(negedge ref_clk) begin
    if (!code_valid) begin
      if (fifo.size() != 0 && $urandom_range(3) != 0) begin
        code_valid = 1'b1;
        code_byte = fifo[0];
      end else begin
        code_byte = ~code_byte;
      end
    end
  end
endmodule : mod_progmem

// ### testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import mod_pkg::*;
  logic ref_clk, sys_rst, clk_en, code_valid, code_ready, reg_form;
  logic abs_form, no_op, instr_done, en_p, jitter;
  logic [7:0] code_byte, opcode;
  logic [1:0] bank_select;
  logic [LEN_W-1:0] instr_len;
  logic [CYC_W-1:0] instr_cycles;
  logic [REG_W-1:0] reg_index;
  logic [ADDR_W-1:0] reg_addr;
  logic [2:0] abs_high;
  logic [17:0] notes[$];
  logic [17:0] n;
  logic [15:0] t;
  int err_count, comparisons;
  // Opcode, length, cycles
  logic [15:0] tbl[$] = '{16'h2812, 16'h2522, 16'h2612, 16'h2422,
    16'h3812, 16'h3522, 16'h3612, 16'h3422, 16'h9812, 16'h9522,
    16'h9612, 16'h9422, 16'hA314, 16'h0412, 16'h0812, 16'h0522,
    16'h0612, 16'h1412, 16'h5334, 16'h4334, 16'h6334, 16'h5812,
    16'h5522, 16'h5612, 16'h5422, 16'h5222, 16'h4812, 16'h4522,
    16'h4612, 16'h4422, 16'h4222, 16'h6812, 16'h6522, 16'h6612,
    16'h6422, 16'h6222, 16'hE412, 16'hF412, 16'hC412, 16'h2312,
    16'h3312, 16'h0312, 16'h1312, 16'hE812, 16'hF812, 16'hA824,
    16'h8534, 16'h7534, 16'h9314, 16'h8314, 16'hE014, 16'hE214,
    16'hF014, 16'hF214, 16'hC024, 16'hD024, 16'hC812, 16'hC522,
    16'hC612, 16'hD612, 16'h8224, 16'h7224, 16'hA024, 16'h9224,
    16'h1234, 16'h2214, 16'h3214, 16'h4024, 16'h5024, 16'h2034,
    16'h3034, 16'h1034, 16'h6024, 16'h7024, 16'hB534, 16'hB434,
    16'hB834, 16'hB634, 16'hD824, 16'hD534, 16'hA512, 16'h0012};
  logic [15:0] rtbl[12] = '{16'h2812, 16'h3812, 16'h9812, 16'h5812,
    16'h4812, 16'h6812, 16'hE812, 16'hF812, 16'hC812, 16'hA824,
    16'hB834, 16'hD824};
  mod_progmem PM (.ref_clk, .clk_en, .code_ready, .code_valid, .code_byte);
  mod_decode DUT (.ref_clk, .sys_rst, .clk_en, .code_valid, .code_byte,
    .bank_select, .code_ready, .opcode, .instr_len, .instr_cycles,
    .reg_index, .reg_addr, .reg_form, .abs_form, .abs_high, .no_op,
    .instr_done);
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic chk(input string s, input logic [7:0] e, g);
    comparisons++;
    if (g !== e) begin
      $display("unexpected %s exp %h got %h", s, e, g);
      err_count++;
    end
  endtask : chk
  task automatic end_of_test();
    if (err_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  task automatic run(input logic [15:0] x);
    notes.push_back({bank_select, x});
    PM.put(x[15:8]);
    for (int k = 1; k < x[7:4]; k++) PM.put(8'($urandom));
  endtask : run
  task automatic drain();
    for (int k = 0; k < 3000 && notes.size() != 0; k++) @(negedge ref_clk);
  endtask : drain
  always @(posedge ref_clk) en_p <= clk_en;
  always @(negedge ref_clk) begin
    if (jitter) clk_en <= ($urandom_range(3) != 0);
    if (instr_done === 1'b1 && en_p && !sys_rst) begin
      if (notes.size() == 0) chk("spare_done", 8'h00, 8'h01);
      else begin
        n = notes.pop_front();
        chk("opcode", n[15:8], opcode);
        chk("instr_len", 8'(n[7:4]), 8'(instr_len));
        chk("instr_cycles", 8'(n[3:0]), 8'(instr_cycles));
        chk("no_op", 8'(n[15:8] == 8'hA5 || n[15:8] == 8'h00),
          8'(no_op));
        chk("abs_form", 8'(n[11:8] == 4'h1), 8'(abs_form));
        if (n[11:8] == 4'h1) chk("abs_high", 8'(n[15:13]), 8'(abs_high));
        if (n[11]) chk("reg_index", 8'(n[10:8]), 8'(reg_index));
        if (n[11]) chk("reg_addr", 8'({n[17:16], n[10:8]}), 8'(reg_addr));
      end
    end
  end
  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    jitter = 1'b0;
    bank_select = 2'h0;
    err_count = 0;
    comparisons = 0;
    void'($urandom(77));
    repeat (20) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("rst_len", 8'h01, 8'(instr_len));
    chk("rst_cycles", 8'h02, 8'(instr_cycles));
    sys_rst = 1'b0;
    jitter = 1'b1;
    foreach (tbl[i]) run(tbl[i]);
    drain();
    for (int b = 0; b < 4; b++) begin
      bank_select = 2'(b);
      repeat (6) begin
        t = rtbl[$urandom_range(11)];
        t[10:8] = 3'($urandom);
        run(t);
        t = {3'($urandom), ($urandom_range(1) != 0) ? 5'h11 : 5'h01, 8'h24};
        run(t);
      end
      drain();
    end
    chk("pending", 8'h00, 8'(notes.size()));
    end_of_test();
  end
  initial begin
    #(25 * 30000);
    err_count++;
    end_of_test();
  end
endmodule : tb_top
